// [sc_pkg.sv]
// Package of offsets, fields, codes and reset values for the serial channel control block
package sc_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int SC_NCH = 5;
  localparam int SC_I2C_CH_LIMIT = 3;
  localparam int SC_ADDR_W = 11;
  localparam int SC_STATUS_W = 10;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [10:0] SC_CTRL0_OFS [0:4] = '{11'h36C, 11'h2EC, 11'h33C, 11'h1E4, 11'h1EC};
  localparam logic [10:0] SC_MODE_BASE = 11'h400;
  localparam logic [10:0] SC_TXBUF_BASE = 11'h420;
  localparam logic [10:0] SC_RXBUF_BASE = 11'h440;
  localparam logic [10:0] SC_STEP = 11'h004;
  localparam logic [10:0] SC_IRQ_STATUS_OFS = 11'h460;
  localparam logic [10:0] SC_IRQ_MASK_OFS = 11'h464;

  // ----------------------------------------------------------------
  // Control register 0 fields
  // ----------------------------------------------------------------
  localparam int SC_F_RATE_LO = 0;
  localparam int SC_F_RATE_HI = 1;
  localparam int SC_F_RSVD2 = 2;
  localparam int SC_F_TX_EMPTY = 3;
  localparam int SC_F_CTS_DIS = 4;
  localparam int SC_F_DRIVE = 5;
  localparam int SC_F_CLK_POL = 6;
  localparam int SC_F_BIT_ORDER = 7;
  localparam logic [7:0] SC_CTRL0_RESET = 8'h08;

  // ----------------------------------------------------------------
  // Rate source and mode codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SC_SRC_F1 = 2'h0;
  localparam logic [1:0] SC_SRC_F8 = 2'h1;
  localparam logic [1:0] SC_SRC_F2N = 2'h2;
  localparam logic [2:0] SC_MODE_OFF = 3'h0;
  localparam logic [2:0] SC_MODE_SYNC = 3'h1;
  localparam logic [2:0] SC_MODE_I2C = 3'h2;
  localparam logic [2:0] SC_MODE_UART7 = 3'h4;
  localparam logic [2:0] SC_MODE_UART8 = 3'h5;
  localparam logic [2:0] SC_MODE_UART9 = 3'h6;
  localparam logic [2:0] SC_BIT_LAST = 3'h7;

  typedef enum logic {SC_TX_IDLE = 1'b0, SC_TX_SHIFT = 1'b1} sc_tx_state_t;

endpackage : sc_pkg

// [sc_channel_control.sv]
// Serial channel control register 0 block with Avalon-MM slave, shift engines and interrupt
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps

module sc_channel_control (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [10:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Interrupt
  output logic irq,
  // Rate generator count sources
  input wire logic tick_f1,
  input wire logic tick_f8,
  input wire logic tick_f2n,
  output logic [4:0] rate_count_tick,
  output logic [9:0] rate_source_sel,
  // Serial link pins
  input wire logic [4:0] serial_clock_in,
  input wire logic [4:0] rx_data_in,
  input wire logic [4:0] cts_n_in,
  output logic [4:0] tx_data_pin_o,
  output logic [4:0] tx_data_pin_oe,
  output logic [4:0] i2c_clock_pin_o,
  output logic [4:0] i2c_clock_pin_oe
);

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // Every access waits exactly one cycle; read data is latched in the wait cycle
  logic ack;
  logic [9:0] irq_status;
  logic [9:0] irq_mask;
  logic [31:0] rd_mux;
  logic [31:0] rd_ch [0:4];
  wire bus_req = avs_read | avs_write;
  wire wr_go = avs_write & ack & avs_byteenable[0];
  wire [9:0] irq_events;
  wire hit_status = avs_address == sc_pkg::SC_IRQ_STATUS_OFS;
  wire hit_mask = avs_address == sc_pkg::SC_IRQ_MASK_OFS;

  assign avs_waitrequest = bus_req & ~ack;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack <= 1'b0;
    end else begin
      ack <= bus_req & ~ack;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~ack) begin
      avs_readdata <= rd_mux;
    end
  end

  // Unmapped addresses read as zero and ignore writes
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_status) begin
      rd_mux[9:0] = irq_status;
    end
    if (hit_mask) begin
      rd_mux[9:0] = irq_mask;
    end
    for (int k = 0; k < sc_pkg::SC_NCH; k++) begin
      rd_mux = rd_mux | rd_ch[k];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  wire [9:0] clr_bits = (wr_go & hit_status) ? avs_writedata[9:0] : 10'h000;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_status <= 10'h000;
      irq_mask <= 10'h000;
    end else begin
      // A new event wins over a clear in the same cycle
      irq_status <= (irq_status & ~clr_bits) | irq_events;
      if (wr_go & hit_mask) begin
        irq_mask <= avs_writedata[9:0];
      end
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ----------------------------------------------------------------
  // Per-channel control, pins and shift engines
  // ----------------------------------------------------------------
  for (genvar ch = 0; ch < sc_pkg::SC_NCH; ch++) begin : g_ch
    localparam bit HAS_I2C = ch < sc_pkg::SC_I2C_CH_LIMIT;
    localparam logic [10:0] CH_STEP = 11'(ch * 4);
    localparam logic [10:0] MODE_OFS = sc_pkg::SC_MODE_BASE + CH_STEP;
    localparam logic [10:0] TXBUF_OFS = sc_pkg::SC_TXBUF_BASE + CH_STEP;
    localparam logic [10:0] RXBUF_OFS = sc_pkg::SC_RXBUF_BASE + CH_STEP;

    logic [7:0] ctrl;
    logic [2:0] mode;
    logic [7:0] tx_buf;
    logic tx_pend;
    sc_pkg::sc_tx_state_t tx_state;
    logic [2:0] tx_cnt;
    logic tx_bit;
    logic [7:0] rx_sh;
    logic [2:0] rx_cnt;
    logic [7:0] rx_buf;
    logic tx_done;
    logic rx_done;
    logic [1:0] clk_sync;
    logic clk_prev;
    logic [1:0] rx_sync;
    logic [1:0] cts_sync;

    wire hit_ctrl = avs_address == sc_pkg::SC_CTRL0_OFS[ch];
    wire hit_mode = avs_address == MODE_OFS;
    wire hit_tx = avs_address == TXBUF_OFS;
    wire hit_rx = avs_address == RXBUF_OFS;
    wire tx_empty = ~tx_pend & (tx_state == sc_pkg::SC_TX_IDLE);
    wire [1:0] src_sel = ctrl[sc_pkg::SC_F_RATE_HI:sc_pkg::SC_F_RATE_LO];
    wire mode_on = mode != sc_pkg::SC_MODE_OFF;
    wire mode_i2c = HAS_I2C && (mode == sc_pkg::SC_MODE_I2C);
    // Order applies in sync, 8-bit UART and, on I2C-capable channels, I2C
    wire order_ok = (mode == sc_pkg::SC_MODE_SYNC) | (mode == sc_pkg::SC_MODE_UART8) | mode_i2c;
    wire msb_first = ctrl[sc_pkg::SC_F_BIT_ORDER] & order_ok;
    wire pol = ctrl[sc_pkg::SC_F_CLK_POL];
    wire clk_rise = clk_sync[1] & ~clk_prev;
    wire clk_fall = ~clk_sync[1] & clk_prev;
    wire out_edge = pol ? clk_rise : clk_fall;
    wire in_edge = pol ? clk_fall : clk_rise;
    wire cts_ok = ctrl[sc_pkg::SC_F_CTS_DIS] | ~cts_sync[1];
    wire [2:0] tx_idx = msb_first ? (sc_pkg::SC_BIT_LAST - tx_cnt) : tx_cnt;
    wire [2:0] first_idx = msb_first ? sc_pkg::SC_BIT_LAST : 3'h0;
    wire open_drain = HAS_I2C && ctrl[sc_pkg::SC_F_DRIVE];
    wire [7:0] ctrl_wr = avs_writedata[7:0];
    wire [7:0] ctrl_rd;

    // Drive bit exists only on I2C-capable channels; elsewhere it reads zero
    if (HAS_I2C) begin : g_drv
      assign ctrl_rd = {ctrl[7:4], tx_empty, ctrl[2:0]};
    end else begin : g_nodrv
      assign ctrl_rd = {ctrl[7:6], 1'b0, ctrl[4], tx_empty, ctrl[2:0]};
    end

    assign rd_ch[ch] = hit_ctrl ? {24'h00_0000, ctrl_rd} :
                       hit_mode ? {29'h0000_0000, mode} :
                       hit_tx ? {24'h00_0000, tx_buf} :
                       hit_rx ? {24'h00_0000, rx_buf} : 32'h0000_0000;

    // Control register; the empty flag position is never stored
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        ctrl <= sc_pkg::SC_CTRL0_RESET & ~(8'h01 << sc_pkg::SC_F_TX_EMPTY);
        mode <= sc_pkg::SC_MODE_OFF;
      end else begin
        if (wr_go & hit_ctrl) begin
          ctrl <= ctrl_wr & ~(8'h01 << sc_pkg::SC_F_TX_EMPTY);
          if (!HAS_I2C) begin
            ctrl[sc_pkg::SC_F_DRIVE] <= 1'b0;
          end
        end
        if (wr_go & hit_mode) begin
          mode <= avs_writedata[2:0];
        end
      end
    end

    // Link pins come from outside the clock domain
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        // Start at the idle-high level of the link clock so no false edge follows reset
        clk_sync <= 2'h3;
        clk_prev <= 1'b1;
        rx_sync <= 2'h3;
        cts_sync <= 2'h3;
      end else begin
        clk_sync <= {clk_sync[0], serial_clock_in[ch]};
        clk_prev <= clk_sync[1];
        rx_sync <= {rx_sync[0], rx_data_in[ch]};
        cts_sync <= {cts_sync[0], cts_n_in[ch]};
      end
    end

    // Transmit engine: frame starts only when clear-to-send allows it
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        tx_buf <= 8'h00;
        tx_pend <= 1'b0;
        tx_state <= sc_pkg::SC_TX_IDLE;
        tx_cnt <= 3'h0;
        tx_bit <= 1'b1;
        tx_done <= 1'b0;
      end else begin
        tx_done <= 1'b0;
        if (wr_go & hit_tx & ~tx_pend) begin
          tx_buf <= avs_writedata[7:0];
          tx_pend <= 1'b1;
        end
        if (out_edge & mode_on) begin
          case (tx_state)
            sc_pkg::SC_TX_IDLE: begin
              if (tx_pend & cts_ok) begin
                tx_state <= sc_pkg::SC_TX_SHIFT;
                tx_pend <= 1'b0;
                tx_cnt <= 3'h0;
                tx_bit <= tx_buf[first_idx];
              end
            end
            sc_pkg::SC_TX_SHIFT: begin
              if (tx_cnt == sc_pkg::SC_BIT_LAST) begin
                tx_state <= sc_pkg::SC_TX_IDLE;
                tx_bit <= 1'b1;
                tx_done <= 1'b1;
              end else begin
                tx_cnt <= tx_cnt + 3'h1;
                tx_bit <= tx_buf[tx_idx + 3'h1 - 3'(msb_first) * 3'h2];
              end
            end
            default: begin
              tx_state <= sc_pkg::SC_TX_IDLE;
            end
          endcase
        end
      end
    end

    // Receive engine: samples on the edge opposite to transmit
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        rx_sh <= 8'h00;
        rx_cnt <= 3'h0;
        rx_buf <= 8'h00;
        rx_done <= 1'b0;
      end else begin
        rx_done <= 1'b0;
        if (in_edge & mode_on) begin
          rx_cnt <= rx_cnt + 3'h1;
          if (msb_first) begin
            rx_sh <= {rx_sh[6:0], rx_sync[1]};
          end else begin
            rx_sh <= {rx_sync[1], rx_sh[7:1]};
          end
          if (rx_cnt == sc_pkg::SC_BIT_LAST) begin
            rx_buf <= msb_first ? {rx_sh[6:0], rx_sync[1]} : {rx_sync[1], rx_sh[7:1]};
            rx_done <= 1'b1;
          end
        end
      end
    end

    // Rate generator source selection; code 3 selects no source
    assign rate_source_sel[2*ch+1:2*ch] = src_sel;
    assign rate_count_tick[ch] = (src_sel == sc_pkg::SC_SRC_F1) ? tick_f1 :
                                 (src_sel == sc_pkg::SC_SRC_F8) ? tick_f8 :
                                 (src_sel == sc_pkg::SC_SRC_F2N) ? tick_f2n : 1'b0;

    // Open-drain only pulls low; push-pull drives both levels when enabled
    assign tx_data_pin_o[ch] = open_drain ? 1'b0 : tx_bit;
    assign tx_data_pin_oe[ch] = mode_on & (open_drain ? ~tx_bit : 1'b1);
    assign i2c_clock_pin_o[ch] = open_drain ? 1'b0 : clk_sync[1];
    assign i2c_clock_pin_oe[ch] = mode_i2c & (open_drain ? ~clk_sync[1] : 1'b1);

    assign irq_events[ch] = tx_done;
    assign irq_events[ch + sc_pkg::SC_NCH] = rx_done;
  end

endmodule : sc_channel_control

// [sc_channel_control_monitor.sv]
// Port checker of the serial channel control block
`timescale 1ns/1ps
module sc_channel_control_monitor (
  // Clock and bus
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [10:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Rate, link and interrupt
  input wire logic irq,
  input wire logic tick_f1,
  input wire logic tick_f8,
  input wire logic tick_f2n,
  input wire logic [4:0] rate_count_tick,
  input wire logic [9:0] rate_source_sel,
  input wire logic [4:0] serial_clock_in,
  input wire logic [4:0] tx_data_pin_o,
  input wire logic [4:0] tx_data_pin_oe
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  chk_wait_first: assert property ($rose(avs_read) || $rose(avs_write) |-> avs_waitrequest)
    else $error("no wait cycle");
  chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait too long");
  chk_rate_f1: assert property (rate_source_sel[1:0] == 2'h0 |-> rate_count_tick[0] == tick_f1)
    else $error("f1 tick wrong");
  chk_rate_f8: assert property (rate_source_sel[1:0] == 2'h1 |-> rate_count_tick[0] == tick_f8)
    else $error("f8 tick wrong");
  chk_rate_div: assert property (rate_source_sel[1:0] == 2'h2 |-> rate_count_tick[0] == tick_f2n)
    else $error("f2n tick wrong");
  chk_rate_none: assert property (rate_source_sel[1:0] == 2'h3 |-> !rate_count_tick[0])
    else $error("tick on unused code");
  // Window of three cycles stays below half a link period
  chk_tx_on_edge: assert property ($changed(tx_data_pin_o[0]) && $stable(tx_data_pin_oe[0])
    |-> $past(serial_clock_in[0], 2) != $past(serial_clock_in[0], 5)) else $error("tx moved off edge");
  chk_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address == 11'h7FC
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  chk_reset_pins: assert property ($fell(rst) |-> tx_data_pin_oe == 5'h00 && !irq)
    else $error("pins active after reset");
  cov_write: cover property (avs_write && !avs_waitrequest);
  cov_irq: cover property ($rose(irq));
  cov_tx: cover property ($changed(tx_data_pin_o[0]));
endmodule : sc_channel_control_monitor
bind sc_channel_control sc_channel_control_monitor u_mon (.*);

// [sc_serial_partner.sv]
// External serial device model on channel 0
`timescale 1ns/1ps
module sc_serial_partner (
  // Link toward the block
  output logic [4:0] serial_clock_in,
  output logic [4:0] rx_data_in,
  output logic [4:0] cts_n_in,
  // Transmit pin from the block
  input wire logic [4:0] tx_data_pin_o,
  input wire logic [4:0] tx_data_pin_oe
);
  logic [7:0] got;
  logic line;
  // Released open-drain line reads high through the pull-up
  assign line = tx_data_pin_oe[0] ? tx_data_pin_o[0] : 1'b1;
  initial begin
    serial_clock_in = 5'h1F;
    rx_data_in = 5'h1F;
    cts_n_in = 5'h00;
  end
  task automatic frame(input logic pol, input logic [7:0] rx_bits);
    // Clock stands still at its idle level between frames
    if (serial_clock_in[0] !== ~pol) begin
      serial_clock_in[0] = ~pol;
      #400;
    end
    #137;
    for (int i = 0; i < 9; i++) begin
      serial_clock_in[0] = pol;
      rx_data_in[0] = (i < 8) ? rx_bits[i] : ~rx_data_in[0];
      #400;
      serial_clock_in[0] = ~pol;
      if (i < 8) got[i] = line;
      #400;
    end
  endtask : frame
endmodule : sc_serial_partner

// [sc_channel_control_tb_top.sv]
// Self-checking bench of the serial channel control block
`timescale 1ns/1ps
module sc_channel_control_tb_top;
  logic clk_sys, rst, avs_read, avs_write, avs_waitrequest, irq;
  logic tick_f1, tick_f8, tick_f2n;
  logic [3:0] avs_byteenable;
  logic [10:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [4:0] rate_count_tick, serial_clock_in, rx_data_in, cts_n_in;
  logic [4:0] tx_data_pin_o, tx_data_pin_oe, i2c_clock_pin_o, i2c_clock_pin_oe;
  logic [9:0] rate_source_sel;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  localparam logic [10:0] ofs0 = sc_pkg::SC_CTRL0_OFS[0];
  sc_channel_control uut (.*);
  sc_serial_partner peer (.*);
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [3:0] be, input logic [10:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_byteenable <= be;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    // Look at waitrequest mid-cycle so the accepting rising edge is known without a race
    do begin
      @(negedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    @(posedge clk_sys);
    q = avs_readdata;
    chk({31'h0, n >= 40}, 32'h0, "bus hang");
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [10:0] a, input logic [31:0] d);
    bus(1'b1, 4'h1, a, d);
  endtask : wr
  task automatic rd(input logic [10:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, 4'h1, a, 32'h0);
    chk(q, exp, what);
  endtask : rd
  task automatic chk_irq(input logic e);
    @(posedge clk_sys);
    chk({31'h0, irq}, {31'h0, e}, "irq");
  endtask : chk_irq
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    for (int c = 0; c < 5; c++) rd(sc_pkg::SC_CTRL0_OFS[c], 32'h08, "reset");
    rd(11'h7FC, 32'h0, "unmapped");
    bus(1'b1, 4'h0, ofs0, 32'h80);
    rd(ofs0, 32'h08, "lane off");
    wr(ofs0, 32'h00);
    rd(ofs0, 32'h08, "flag write");
    wr(sc_pkg::SC_CTRL0_OFS[3], 32'hF3);
    rd(sc_pkg::SC_CTRL0_OFS[3], 32'hDB, "ch3 bit5");
    $display("t_regs done");
  endtask : t_regs
  task automatic t_rate;
    logic e;
    for (int p = 0; p < 2; p++) for (int c = 0; c < 4; c++) begin
      wr(ofs0, c);
      {tick_f1, tick_f8, tick_f2n} <= p ? 3'h2 : 3'h5;
      @(posedge clk_sys);
      @(posedge clk_sys);
      e = (c == 3) ? 1'b0 : (p ? c == 1 : c != 1);
      chk({31'h0, rate_count_tick[0]}, {31'h0, e}, "tick");
      chk({30'h0, rate_source_sel[1:0]}, c, "source");
    end
    $display("t_rate done");
  endtask : t_rate
  task automatic t_drive;
    wr(sc_pkg::SC_MODE_BASE, 32'h1);
    wr(ofs0, 32'h20);
    @(posedge clk_sys);
    chk({30'h0, tx_data_pin_o[0], tx_data_pin_oe[0]}, 32'h0, "open drain");
    wr(ofs0, 32'h00);
    @(posedge clk_sys);
    chk({30'h0, tx_data_pin_o[0], tx_data_pin_oe[0]}, 32'h3, "push pull");
    $display("t_drive done");
  endtask : t_drive
  task automatic t_tx(input logic [2:0] mode, input logic [7:0] ctrl, input logic [7:0] data,
                      input logic [7:0] exp, input logic cts);
    wr(sc_pkg::SC_MODE_BASE, {29'h0, mode});
    wr(ofs0, {24'h0, ctrl});
    peer.cts_n_in[0] = cts;
    wr(sc_pkg::SC_TXBUF_BASE, {24'h0, data});
    rd(ofs0, {24'h0, ctrl}, "busy");
    peer.frame(ctrl[6], ~data);
    if (cts && !ctrl[4]) begin
      rd(ofs0, {24'h0, ctrl}, "cts hold");
      peer.cts_n_in[0] = 1'b0;
      peer.frame(ctrl[6], data);
    end
    chk({24'h0, peer.got}, {24'h0, exp}, "wire");
    rd(ofs0, {24'h0, ctrl | 8'h08}, "empty");
    wr(sc_pkg::SC_IRQ_MASK_OFS, 32'h0);
    chk_irq(1'b0);
    wr(sc_pkg::SC_IRQ_MASK_OFS, 32'h1);
    chk_irq(1'b1);
    wr(sc_pkg::SC_IRQ_STATUS_OFS, 32'h3FF);
    chk_irq(1'b0);
    $display("t_tx mode %h ctrl %h done", mode, ctrl);
  endtask : t_tx
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 8000) begin
      num_errors++;
      $display("BAD t=%0t timeout", $time);
      tally_and_finish;
    end
  end
  initial begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 11'h000;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h1;
    {tick_f1, tick_f8, tick_f2n} = 3'h0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs;
    t_rate;
    t_drive;
    t_tx(3'h1, 8'h00, 8'hA5, 8'hA5, 1'b0);
    t_tx(3'h1, 8'h80, 8'h01, 8'h80, 1'b0);
    t_tx(3'h5, 8'h80, 8'h03, 8'hC0, 1'b0);
    t_tx(3'h2, 8'h80, 8'h03, 8'hC0, 1'b0);
    t_tx(3'h4, 8'h00, 8'h3C, 8'h3C, 1'b0);
    t_tx(3'h6, 8'h00, 8'hC3, 8'hC3, 1'b0);
    t_tx(3'h1, 8'h20, 8'h4B, 8'h4B, 1'b0);
    t_tx(3'h1, 8'h10, 8'h96, 8'h96, 1'b1);
    t_tx(3'h1, 8'h00, 8'h5A, 8'h5A, 1'b1);
    t_tx(3'h1, 8'h40, 8'h69, 8'h69, 1'b0);
    tally_and_finish;
  end
endmodule : sc_channel_control_tb_top
